// ### logic/pbws_top.sv
// module: pushbutton wiper stepper, control logic of a 64-tap digital rheostat
// Notes on behaviour
// - wiper holds one of 64 taps as a 6-bit value
// - all three control inputs are asserted low, idle high
// - a pulse starts at the high-to-low edge of an input
// - a low pulse over 1 ms and up to 1 s moves exactly one tap
// - on the up and down contacts, high gaps under 1 ms merge neighbouring pulses into one
// - held past 1 s, one more tap every 100 ms until release
// - single-button mode steps both ways from up contact, ignores down contact
// - down contact tied high at power-up selects single mode, fixed until power-up
// - single mode first move is opposite to the previous activity's direction
// - single mode reverses after over 1 s idle or at a range end
// - step input moves both ways by single-mode direction rules, in either mode
// - dual mode: up contact increments, down contact decrements, no reversal wait
// - dual mode: at an end the wiper stays until an opposite input
// - up and down contacts are debounced internally
// - power-up loads the wiper from the nonvolatile cells
// - a change is saved 2 s after it; the first change always saved
// - later saves only when moved at least eight taps from the stored value
// - worn cells: stepping continues, power-up restores the last good value
// - one-second hold and idle thresholds may be off by up to 15 percent
`timescale 1ns/1ns
`default_nettype none
module pbws_top
    import pbws_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES,
    parameter int WEAR_MAX = WEAR_LIMIT
)
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_up_contact_n,
    input  wire logic             i_down_contact_n,
    input  wire logic             i_step_n,
    input  wire logic             i_down_tied_high,
    output logic      [POS_W-1:0] o_wiper,
    output logic                  o_single_mode,
    output logic                  o_dir_up,
    output logic                  o_nv_write
);
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic [TICK_CNT_W-1:0] next_tick_cnt;
    logic                  tick;
    logic                  next_tick;
    logic [CH_COUNT-1:0]   pins_n;
    logic [CH_COUNT-1:0]   raw_active;
    logic [CH_COUNT-1:0]   ch_en;
    logic [MS_CNT_W-1:0]   hold_cnt      [CH_COUNT];
    logic [MS_CNT_W-1:0]   next_hold_cnt [CH_COUNT];
    logic                  ch_fire       [CH_COUNT];
    pbws_state_e           state;
    pbws_state_e           next_state;
    pbws_mode_e            mode;
    pbws_mode_e            next_mode;
    logic [1:0]            load_cnt;
    logic [1:0]            next_load_cnt;
    logic                  strap_a;
    logic                  strap_b;
    logic [POS_W-1:0]      wiper;
    logic [POS_W-1:0]      next_wiper;
    logic                  dir_up;
    logic                  next_dir_up;
    logic                  armed;
    logic                  next_armed;
    logic                  flip_pend;
    logic                  next_flip_pend;
    logic [MS_CNT_W-1:0]   idle_cnt;
    logic [MS_CNT_W-1:0]   next_idle_cnt;
    logic                  save_pend;
    logic                  next_save_pend;
    logic                  first_done;
    logic                  next_first_done;
    logic [MS_CNT_W-1:0]   save_cnt;
    logic [MS_CNT_W-1:0]   next_save_cnt;
    logic                  nv_write;
    logic                  next_nv_write;
    logic [POS_W-1:0]      nv_pos;
    logic                  nv_up;
    logic                  eff_up;
    logic                  dir_active;
    logic [POS_W-1:0]      diff;

    // absolute tap distance, used for the save threshold and by the checks
    function automatic logic [POS_W-1:0] tap_dist(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
        tap_dist = (a > b) ? a - b : b - a;
    endfunction

    // millisecond timebase; every slower rate counts these enables
    always_comb
    begin
        next_tick     = 1'b0;
        next_tick_cnt = tick_cnt + TICK_CNT_W'(1);
        if (tick_cnt == TICK_CNT_W'(TICK_DIV - 1))
        begin
            next_tick_cnt = '0;
            next_tick     = 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        tick_cnt <= i_rst ? '0 : next_tick_cnt;
        tick     <= i_rst ? 1'b0 : next_tick;
    end

    assign pins_n = {i_step_n, i_down_contact_n, i_up_contact_n};
    // down contact is dead in single mode; nothing counts before the mode is known
    assign ch_en  = (state != ST_RUN) ? 3'h0 : (mode == MODE_SINGLE) ? 3'h5 : 3'h7;

    // one filter and one hold timer per control input
    for (genvar g = 0; g < CH_COUNT; g++)
    begin : g_ch
        pbws_filter #(
            .STABLE_TICKS ((g == CH_STEP) ? STEP_FILTER_TICKS : DEBOUNCE_TICKS)
        ) u_filter (
            .i_clk    (i_clk),
            .i_rst    (i_rst),
            .i_tick   (tick),
            .i_pin_n  (pins_n[g]),
            .o_active (raw_active[g])
        );

        always_comb
        begin
            next_hold_cnt[g] = hold_cnt[g];
            ch_fire[g]       = 1'b0;
            // a release clears the timer, so the next falling edge starts a new pulse
            if (!(raw_active[g] && ch_en[g]))
                next_hold_cnt[g] = '0;
            else if (tick)
            begin
                // first tap once the low level has lasted past the minimum width
                if (hold_cnt[g] == PRESS_TICKS - 11'h001)
                begin
                    ch_fire[g]       = 1'b1;
                    next_hold_cnt[g] = hold_cnt[g] + 11'h001;
                end
                // after the one-second hold, one tap per repeat period
                else if (hold_cnt[g] == HOLD_TICKS + REPEAT_TICKS - 11'h001)
                begin
                    ch_fire[g]       = 1'b1;
                    next_hold_cnt[g] = HOLD_TICKS;
                end
                else
                    next_hold_cnt[g] = hold_cnt[g] + 11'h001;
            end
        end

        always_ff @(posedge i_clk)
        begin
            hold_cnt[g] <= i_rst ? '0 : next_hold_cnt[g];
        end
    end

    pbws_nvstore #(
        .WEAR_MAX (WEAR_MAX)
    ) u_nv (
        .i_clk   (i_clk),
        .i_write (nv_write),
        .i_pos   (wiper),
        .i_up    (dir_up),
        .o_pos   (nv_pos),
        .o_up    (nv_up),
        .o_worn  ()
    );

    always_comb
    begin
        next_state      = state;
        next_mode       = mode;
        next_load_cnt   = load_cnt;
        next_wiper      = wiper;
        next_dir_up     = dir_up;
        next_armed      = armed;
        next_flip_pend  = flip_pend;
        next_idle_cnt   = idle_cnt;
        next_save_pend  = save_pend;
        next_first_done = first_done;
        next_save_cnt   = save_cnt;
        next_nv_write   = 1'b0;
        eff_up          = dir_up ^ flip_pend;
        dir_active      = raw_active[CH_STEP] || (mode == MODE_SINGLE && raw_active[CH_UP]);
        diff            = tap_dist(wiper, nv_pos);
        case (state)
            ST_LOAD:
            begin
                // wait for the strap synchroniser to settle, then fix mode and restore
                next_load_cnt = load_cnt + 2'h1;
                if (load_cnt == STRAP_CYCLES - 2'h1)
                begin
                    next_state  = ST_RUN;
                    next_mode   = strap_b ? MODE_SINGLE : MODE_DUAL;
                    next_wiper  = nv_pos;
                    next_dir_up = ~nv_up;
                end
            end
            ST_RUN:
            begin
                // idle time on the bidirectional sources arms a reversal
                if (dir_active)
                    next_idle_cnt = '0;
                else if (tick && armed && idle_cnt != IDLE_TICKS)
                begin
                    next_idle_cnt = idle_cnt + 11'h001;
                    if (idle_cnt == IDLE_TICKS - 11'h001) // exact 1 s sits inside the allowed spread
                        next_flip_pend = 1'b1;
                end
                // simultaneous taps from two inputs in one tick: only one moves, dual-mode up first, then down, then up or step
                if (ch_fire[CH_UP] && mode == MODE_DUAL)
                begin
                    if (wiper != POS_MAX)
                        next_wiper = wiper + 6'h01;
                end
                else if (ch_fire[CH_DOWN])
                begin
                    if (wiper != POS_MIN)
                        next_wiper = wiper - 6'h01;
                end
                else if (ch_fire[CH_UP] || ch_fire[CH_STEP])
                begin
                    // an end turns the direction around instead of stalling
                    if (eff_up && wiper == POS_MAX)
                        eff_up = 1'b0;
                    else if (!eff_up && wiper == POS_MIN)
                        eff_up = 1'b1;
                    next_wiper     = eff_up ? wiper + 6'h01 : wiper - 6'h01;
                    next_dir_up    = eff_up;
                    next_flip_pend = 1'b0;
                    next_armed     = 1'b1;
                    next_idle_cnt  = '0;
                end
                // every change restarts the save delay
                if (next_wiper != wiper)
                begin
                    next_save_pend = 1'b1;
                    next_save_cnt  = '0;
                end
                else if (save_pend && tick)
                begin
                    next_save_cnt = save_cnt + 11'h001;
                    if (save_cnt == SAVE_TICKS - 11'h001)
                    begin
                        next_save_pend  = 1'b0;
                        // first change always kept, later ones only past the threshold
                        if (!first_done || diff >= SAVE_STEP)
                        begin
                            next_nv_write   = 1'b1;
                            next_first_done = 1'b1;
                        end
                    end
                end
            end
            default:
                next_state = ST_LOAD;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state      <= ST_LOAD;
            mode       <= MODE_DUAL;
            load_cnt   <= 2'h0;
            strap_a    <= 1'b0;
            strap_b    <= 1'b0;
            wiper      <= POS_MIN;
            dir_up     <= 1'b1;
            armed      <= 1'b0;
            flip_pend  <= 1'b0;
            idle_cnt   <= '0;
            save_pend  <= 1'b0;
            first_done <= 1'b0;
            save_cnt   <= '0;
            nv_write   <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            mode       <= next_mode;
            load_cnt   <= next_load_cnt;
            strap_a    <= i_down_tied_high;
            strap_b    <= strap_a;
            wiper      <= next_wiper;
            dir_up     <= next_dir_up;
            armed      <= next_armed;
            flip_pend  <= next_flip_pend;
            idle_cnt   <= next_idle_cnt;
            save_pend  <= next_save_pend;
            first_done <= next_first_done;
            save_cnt   <= next_save_cnt;
            nv_write   <= next_nv_write;
        end
    end

    assign o_wiper       = wiper;
    assign o_single_mode = (mode == MODE_SINGLE);
    assign o_dir_up      = dir_up;
    assign o_nv_write    = nv_write;

    a_wiper_one_tap: assert property (@(posedge i_clk) disable iff (i_rst)
        state == ST_RUN && $past(state) == ST_RUN && $changed(wiper) |-> tap_dist(wiper, $past(wiper)) == 6'h01)
        else $error("wiper moved by more than one tap");
    a_no_wrap_top: assert property (@(posedge i_clk) disable iff (i_rst)
        state == ST_RUN && wiper == POS_MAX |=> wiper == POS_MAX || wiper == POS_MAX - 6'h01)
        else $error("wiper wrapped past the top tap");
    a_mode_fixed: assert property (@(posedge i_clk) disable iff (i_rst)
        state == ST_RUN |=> state == ST_RUN && $stable(mode))
        else $error("mode changed after power-up");
    a_load_restore: assert property (@(posedge i_clk) disable iff (i_rst)
        state == ST_LOAD ##1 state == ST_RUN |-> wiper == $past(nv_pos) && dir_up == !$past(nv_up))
        else $error("wiper not restored from the cells");
    a_down_ignored: assert property (@(posedge i_clk) disable iff (i_rst)
        mode == MODE_SINGLE && state == ST_RUN |-> hold_cnt[CH_DOWN] == 11'h000 && !ch_fire[CH_DOWN])
        else $error("down contact acted in single mode");
    a_dual_up_inc: assert property (@(posedge i_clk) disable iff (i_rst)
        mode == MODE_DUAL && state == ST_RUN && ch_fire[CH_UP] && wiper != POS_MAX |=> wiper == $past(wiper) + 6'h01)
        else $error("dual mode up tap did not increment");
    a_dual_end_stay: assert property (@(posedge i_clk) disable iff (i_rst) state == ST_RUN &&
        mode == MODE_DUAL && wiper == POS_MIN && !ch_fire[CH_UP] && !ch_fire[CH_STEP] |=> wiper == POS_MIN)
        else $error("dual mode wiper left the bottom end without an up input");
    a_repeat_period: assert property (@(posedge i_clk) disable iff (i_rst)
        ch_fire[CH_UP] && hold_cnt[CH_UP] != 11'h000 |-> hold_cnt[CH_UP] == HOLD_TICKS + REPEAT_TICKS - 11'h001)
        else $error("held tap outside the repeat period");
    a_save_delay: assert property (@(posedge i_clk) disable iff (i_rst)
        nv_write |-> $past(save_cnt) == SAVE_TICKS - 11'h001 && $past(wiper) == wiper
            && (!$past(first_done) || tap_dist(wiper, $past(nv_pos)) >= SAVE_STEP))
        else $error("cell write without the delay or the threshold");
    a_end_reverse: assert property (@(posedge i_clk) disable iff (i_rst)
        state == ST_RUN && ch_fire[CH_STEP] && !ch_fire[CH_UP] && !ch_fire[CH_DOWN] && wiper == POS_MAX
            |=> wiper == POS_MAX - 6'h01 && !dir_up)
        else $error("step input did not reverse at the top end");
endmodule
`default_nettype wire

// ### logic/pbws_pkg.sv
// package: constants and types of the pushbutton wiper stepper
package pbws_pkg;
    localparam int          POS_W             = 6;
    localparam int          TAP_COUNT         = 64;
    localparam logic [5:0]  POS_MAX           = 6'h3F;
    localparam logic [5:0]  POS_MIN           = 6'h00;
    localparam int          CLK_HZ            = 100_000_000;
    localparam int          TICK_US           = 1000;
    localparam int          TICK_CYCLES       = CLK_HZ / 1_000_000 * TICK_US;
    localparam int          TICK_CNT_W        = 17;
    localparam int          MS_CNT_W          = 11;
    localparam int          PRESS_MS          = 1;
    localparam int          HOLD_MS           = 1000;
    localparam int          REPEAT_MS         = 100;
    localparam int          IDLE_MS           = 1000;
    localparam int          SAVE_MS           = 2000;
    localparam int          DEBOUNCE_MS       = 2;
    localparam int          STEP_FILTER_MS    = 1;
    localparam logic [10:0] PRESS_TICKS       = 11'(PRESS_MS * 1000 / TICK_US);
    localparam logic [10:0] HOLD_TICKS        = 11'(HOLD_MS * 1000 / TICK_US);
    localparam logic [10:0] REPEAT_TICKS      = 11'(REPEAT_MS * 1000 / TICK_US);
    localparam logic [10:0] IDLE_TICKS        = 11'(IDLE_MS * 1000 / TICK_US);
    localparam logic [10:0] SAVE_TICKS        = 11'(SAVE_MS * 1000 / TICK_US);
    localparam logic [1:0]  DEBOUNCE_TICKS    = 2'(DEBOUNCE_MS * 1000 / TICK_US);
    localparam logic [1:0]  STEP_FILTER_TICKS = 2'(STEP_FILTER_MS * 1000 / TICK_US);
    localparam logic [5:0]  SAVE_STEP         = 6'h08;
    localparam logic [5:0]  NV_INIT_POS       = 6'h00;
    localparam logic        NV_INIT_UP        = 1'b0;
    localparam int          WEAR_LIMIT        = 80_000;
    localparam int          WEAR_CNT_W        = 17;
    localparam logic [1:0]  STRAP_CYCLES      = 2'h3;
    localparam int          CH_UP             = 0;
    localparam int          CH_DOWN           = 1;
    localparam int          CH_STEP           = 2;
    localparam int          CH_COUNT          = 3;

    typedef enum logic {MODE_DUAL, MODE_SINGLE} pbws_mode_e;
    typedef enum logic {ST_LOAD, ST_RUN} pbws_state_e;
endpackage

// ### logic/pbws_filter.sv
// module: pin synchroniser and millisecond debounce filter for one active-low input
`timescale 1ns/1ns
`default_nettype none
module pbws_filter
    import pbws_pkg::*;
#(
    parameter logic [1:0] STABLE_TICKS = DEBOUNCE_TICKS
)
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_tick,
    input  wire logic i_pin_n,
    output logic      o_active
);
    logic       sync_a;
    logic       sync_b;
    logic       active;
    logic [1:0] cnt;
    logic       next_sync_a;
    logic       next_sync_b;
    logic       next_active;
    logic [1:0] next_cnt;

    always_comb
    begin
        next_sync_a = i_pin_n;
        next_sync_b = sync_a;
        next_active = active;
        next_cnt    = cnt;
        // low means asserted, so a mismatch is pin level equal to the active flag
        if (sync_b != active)
        begin
            next_cnt = 2'h0;
        end
        else if (i_tick)
        begin
            // with STABLE_TICKS of 2, short glitches and short high gaps never reach the count; at 1, any level seen on a tick is taken
            if (cnt == STABLE_TICKS - 2'h1)
            begin
                next_active = ~active;
                next_cnt    = 2'h0;
            end
            else
            begin
                next_cnt = cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
            active <= 1'b0;
            cnt    <= 2'h0;
        end
        else
        begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
            active <= next_active;
            cnt    <= next_cnt;
        end
    end

    assign o_active = active;

    a_filter_on_tick: assert property (@(posedge i_clk) disable iff (i_rst)
        $changed(active) |-> $past(i_tick) && $past(sync_b) == $past(active))
        else $error("filtered level changed off a tick or without a mismatch");
endmodule
`default_nettype wire

// ### logic/pbws_nvstore.sv
// module: nonvolatile cells for wiper position and last direction, with wear-out
`timescale 1ns/1ns
`default_nettype none
module pbws_nvstore
    import pbws_pkg::*;
#(
    parameter int WEAR_MAX = WEAR_LIMIT
)
(
    input  wire logic             i_clk,
    input  wire logic             i_write,
    input  wire logic [POS_W-1:0] i_pos,
    input  wire logic             i_up,
    output logic      [POS_W-1:0] o_pos,
    output logic                  o_up,
    output logic                  o_worn
);
    // cells survive i_rst on purpose: reset stands for power-up, which must not erase them
    logic [POS_W:0]      cells [1]      = '{{NV_INIT_UP, NV_INIT_POS}};
    logic [WEAR_CNT_W-1:0] wear_cnt     = '0;
    logic [POS_W:0]      next_cell;
    logic [WEAR_CNT_W-1:0] next_wear_cnt;
    logic                worn;

    always_comb
    begin
        worn          = (wear_cnt >= WEAR_CNT_W'(WEAR_MAX));
        next_cell     = cells[0];
        next_wear_cnt = wear_cnt;
        // a worn array drops writes; the last good value stays for the next power-up
        if (i_write && !worn)
        begin
            next_cell     = {i_up, i_pos};
            next_wear_cnt = wear_cnt + WEAR_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk)
    begin
        cells[0] <= next_cell;
        wear_cnt <= next_wear_cnt;
    end

    assign o_pos  = cells[0][POS_W-1:0];
    assign o_up   = cells[0][POS_W];
    assign o_worn = worn;
endmodule
`default_nettype wire

// ### tb/pbws_buttons.sv
// partner model: pushbuttons and step source driving the control pins
`timescale 1ns/1ns
`default_nettype none
module pbws_buttons
#(
    parameter int TICK = 10
)
(
    input  wire logic i_clk,
    output logic      o_up_n,
    output logic      o_down_n,
    output logic      o_step_n,
    output logic      o_tie
);
    logic [2:0] pins_n;
    assign o_up_n   = pins_n[0];
    assign o_down_n = pins_n[1];
    assign o_step_n = pins_n[2];
    initial
    begin
        pins_n = 3'h7; // idle high on pull-ups, down released through power-up
        o_tie  = 1'b0;
    end
    // low for lo ms then released for hi ms; starts and ends just after an edge
    task automatic pulse(input int ch, input int lo, input int hi);
        #1;
        pins_n[ch] = 1'b0;
        repeat (lo * TICK) @(posedge i_clk);
        #1;
        pins_n[ch] = 1'b1;
        repeat (hi * TICK) @(posedge i_clk);
    endtask
    // pad sense of the down contact; only changed while reset is held
    task automatic strap(input logic t);
        o_tie = t;
    endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// testbench: scenarios for the pushbutton wiper stepper
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("wrong value at %0t: %h %h", $time, g, e); end end
module tb;
    import pbws_pkg::*;
    localparam int TICK     = 5;
    // scenarios take about 12.3 s of tick time; the margin covers filter delays
    localparam int WATCH_MS = 13000;
    logic             clk;
    logic             rst;
    logic             up_n;
    logic             down_n;
    logic             step_n;
    logic             tie;
    logic [POS_W-1:0] wiper;
    logic             single;
    logic             dir_up;
    logic             nv_write;
    int               errors;
    int               checks;
    int               writes;
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    pbws_buttons #(.TICK(TICK)) u_btn (.i_clk(clk), .o_up_n(up_n), .o_down_n(down_n), .o_step_n(step_n), .o_tie(tie));
    pbws_top #(.TICK_DIV(TICK), .WEAR_MAX(2)) u_dut (.i_clk(clk), .i_rst(rst), .i_up_contact_n(up_n),
        .i_down_contact_n(down_n), .i_step_n(step_n), .i_down_tied_high(tie), .o_wiper(wiper),
        .o_single_mode(single), .o_dir_up(dir_up), .o_nv_write(nv_write));
    always @(posedge clk)
        if (nv_write === 1'b1)
            writes++;
    task automatic ms(input int n);
        repeat (n * TICK) @(posedge clk);
    endtask
    // strap is set before release and held, since mode is latched only then
    task automatic power_up(input logic t);
        #1;
        rst = 1'b1;
        u_btn.strap(t);
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        ms(3);
    endtask
    task automatic t_dual;
        `CHK(single, 1'b0)
        `CHK(wiper, 6'h00)
        u_btn.pulse(0, 5, 5);
        `CHK(wiper, 6'h01)
        u_btn.pulse(1, 5, 5);
        `CHK(wiper, 6'h00)
        u_btn.pulse(1, 5, 5);
        `CHK(wiper, 6'h00)
        u_btn.pulse(0, 1, 5);
        `CHK(wiper, 6'h00)
        u_btn.pulse(0, 5, 1);
        u_btn.pulse(0, 5, 5);
        `CHK(wiper, 6'h01)
    endtask
    task automatic t_step;
        u_btn.pulse(2, 3, 3);
        `CHK(wiper, 6'h02)
        u_btn.pulse(2, 3, 3);
        `CHK(wiper, 6'h03)
        ms(1100);
        u_btn.pulse(2, 3, 3);
        `CHK(wiper, 6'h02)
        `CHK(dir_up, 1'b0)
    endtask
    // waits of 2 s after every change keep the store window clear
    task automatic t_save_hold;
        ms(2020);
        `CHK(writes, 1)
        u_btn.pulse(0, 1150, 5);
        `CHK(wiper, 6'h04)
        ms(2020);
        `CHK(writes, 1)
        u_btn.pulse(0, 1550, 5);
        `CHK(wiper, 6'h0A)
        ms(2020);
        `CHK(writes, 2)
    endtask
    task automatic t_restore;
        power_up(1'b1);
        `CHK(single, 1'b1)
        `CHK(wiper, 6'h0A)
        u_btn.pulse(1, 5, 5);
        `CHK(wiper, 6'h0A)
        u_btn.pulse(0, 5, 5);
        `CHK(wiper, 6'h0B)
    endtask
    // single mode climbs to the top through the step pin, then turns around there
    task automatic t_ends;
        repeat (52) u_btn.pulse(2, 3, 3);
        `CHK(wiper, 6'h3F)
        u_btn.pulse(2, 3, 3);
        `CHK(wiper, 6'h3E)
        `CHK(dir_up, 1'b0)
    endtask
    // cells wear out after two writes here, so the third save is lost at power-up
    task automatic t_wear;
        ms(2020);
        `CHK(writes, 3)
        power_up(1'b1);
        `CHK(wiper, 6'h0A)
        `CHK(dir_up, 1'b1)
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        errors = 0;
        checks = 0;
        writes = 0;
        power_up(1'b0);
        t_dual();
        t_step();
        t_save_hold();
        t_restore();
        t_ends();
        t_wear();
        conclude();
    end
    initial
    begin
        repeat (WATCH_MS * TICK) @(posedge clk);
        errors++;
        conclude();
    end
endmodule
`default_nettype wire
